// file: dfr_exec.sv
`timescale 1ns/1ps
`default_nettype none

module dfr_exec
  import dfr_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic [WORD_W-1:0] instr_word,
  output logic [ADDR_W-1:0]      rf_rd_addr,
  input  wire logic [DATA_W-1:0] rf_rd_data,
  output dfr_wr_s                rf_wr,
  output logic [DATA_W-1:0]      accum,
  output dfr_stat_s              status_upd,
  output dfr_phase_e             phase,
  output logic                   executing
);

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  // Free-running Q1..Q4 ring: every instruction owns exactly one lap,
  // so the decrement never stretches or stalls the instruction cycle
  dfr_phase_e phase_r;
  dfr_phase_e phase_nxt;

  always_comb begin
    case (phase_r)
      PH_Q1:   phase_nxt = PH_Q2;
      PH_Q2:   phase_nxt = PH_Q3;
      PH_Q3:   phase_nxt = PH_Q4;
      PH_Q4:   phase_nxt = PH_Q1;
      // An illegal code falls back to Q1 rather than locking up
      default: phase_nxt = PH_Q1;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_r <= PH_Q1;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Phase strobes
  // ----------------------------------------------------------------
  wire logic q1 = (phase_r == PH_Q1);
  wire logic q2 = (phase_r == PH_Q2);
  wire logic q3 = (phase_r == PH_Q3);
  wire logic q4 = (phase_r == PH_Q4);

  // ----------------------------------------------------------------
  // Decode (Q1)
  // ----------------------------------------------------------------
  wire logic [OPC_HI-OPC_LO:0] opc_field  = instr_word[OPC_HI:OPC_LO];
  wire logic                   dest_field = instr_word[DEST_BIT];
  wire logic [ADDR_W-1:0]      addr_field = instr_word[ADDR_HI:ADDR_LO];
  wire logic                   is_decr    = (opc_field == OPC_DECR);

  // Fields are held for the whole lap: the read address must stay put
  // through Q2 and the write address must still be valid at Q4
  logic              act_r;
  logic              act_nxt;
  logic              dest_r;
  logic              dest_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;

  always_comb begin
    act_nxt  = act_r;
    dest_nxt = dest_r;
    addr_nxt = addr_r;
    if (q1) begin
      act_nxt  = is_decr;
      dest_nxt = dest_field;
      addr_nxt = addr_field;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      act_r  <= 1'b0;
      dest_r <= DEST_ACCUM;
      addr_r <= '0;
    end else begin
      act_r  <= act_nxt;
      dest_r <= dest_nxt;
      addr_r <= addr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read (Q2)
  // ----------------------------------------------------------------
  // The register file answers combinationally; the operand is caught
  // at the edge that ends Q2, so a later write cannot disturb it
  logic [DATA_W-1:0] opnd_r;
  logic [DATA_W-1:0] opnd_nxt;

  wire logic opnd_ld = q2 && act_r;

  always_comb begin
    opnd_nxt = opnd_r;
    if (opnd_ld) begin
      opnd_nxt = rf_rd_data;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      opnd_r <= ZERO;
    end else begin
      opnd_r <= opnd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Process (Q3)
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] res_r;
  logic [DATA_W-1:0] res_nxt;

  // 8-bit modulo difference: 0x00 wraps to 0xFF, which is non-zero
  wire logic [DATA_W-1:0] diff     = opnd_r - ONE;
  wire logic              res_ld   = q3 && act_r;
  wire logic              res_zero = (res_r == ZERO);

  always_comb begin
    res_nxt = res_r;
    if (res_ld) begin
      res_nxt = diff;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      res_r <= ZERO;
    end else begin
      res_r <= res_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Write destination (Q4)
  // ----------------------------------------------------------------
  wire logic wr_go   = q4 && act_r;
  wire logic to_file = (dest_r != DEST_ACCUM);
  wire logic file_wr = wr_go && to_file;
  wire logic acc_wr  = wr_go && !to_file;

  logic [DATA_W-1:0] acc_r;
  logic [DATA_W-1:0] acc_nxt;
  dfr_wr_s           wr_r;
  dfr_wr_s           wr_nxt;
  dfr_stat_s         stat_r;
  dfr_stat_s         stat_nxt;

  // The accumulator keeps its value on every other lap, so a result
  // written back to the file leaves it untouched
  always_comb begin
    acc_nxt = acc_r;
    if (acc_wr) begin
      acc_nxt = res_r;
    end
  end

  // Address and data ride along every cycle; only en qualifies them,
  // which keeps the port free of extra hold logic
  always_comb begin
    wr_nxt      = '0;
    wr_nxt.en   = file_wr;
    wr_nxt.addr = addr_r;
    wr_nxt.data = res_r;
  end

  // Only the zero flag is offered to the status register; the other
  // status bits have no path from this block at all
  always_comb begin
    stat_nxt      = '0;
    stat_nxt.we   = wr_go;
    stat_nxt.zero = res_zero;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_r <= ACC_RST;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_r   <= '0;
      stat_r <= '0;
    end else begin
      wr_r   <= wr_nxt;
      stat_r <= stat_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output comes straight from a flip-flop, so the neighbours
  // see no decode glitches within a phase
  assign rf_rd_addr = addr_r;
  assign rf_wr      = wr_r;
  assign accum      = acc_r;
  assign status_upd = stat_r;
  assign phase      = phase_r;
  assign executing  = act_r;

endmodule

`default_nettype wire

// file: dfr_pkg.sv
package dfr_pkg;

  // ----------------------------------------------------------------
  // Instruction word layout
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W     = 14;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ADDR_W     = 7;
  localparam int unsigned OPC_HI     = 13;
  localparam int unsigned OPC_LO     = 8;
  localparam int unsigned DEST_BIT   = 7;
  localparam int unsigned ADDR_HI    = 6;
  localparam int unsigned ADDR_LO    = 0;
  localparam logic [5:0]  OPC_DECR   = 6'h03;
  localparam logic        DEST_ACCUM = 1'b0;
  localparam logic [7:0]  ONE        = 8'h01;
  localparam logic [7:0]  ZERO       = 8'h00;
  localparam logic [7:0]  ACC_RST    = 8'h00;

  // ----------------------------------------------------------------
  // Phase sequencer, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } dfr_phase_e;

  // Register-file write port
  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dfr_wr_s;

  // Status update
  typedef struct packed {
    logic we;
    logic zero;
  } dfr_stat_s;

endpackage

// file: dfr_rf_model.sv
`timescale 1ns/1ps
`default_nettype none
module dfr_rf_model
  import dfr_pkg::*;
(
  input  wire logic [ADDR_W-1:0] rf_rd_addr,
  output logic [DATA_W-1:0]      rf_rd_data,
  input  wire logic              core_clk,
  input  wire dfr_wr_s           rf_wr
);
  // Each register starts out holding its own address
  logic [DATA_W-1:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = DATA_W'(i);
  assign rf_rd_data = mem[rf_rd_addr];
  always @(posedge core_clk) if (rf_wr.en) mem[rf_wr.addr] <= rf_wr.data;
endmodule
`default_nettype wire

// file: dfr_exec_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dfr_exec_checker
  import dfr_pkg::*;
(
  input wire logic [WORD_W-1:0] instr_word,
  input wire logic [DATA_W-1:0] rf_rd_data,
  input wire logic [DATA_W-1:0] accum,
  input wire logic              core_clk,
  input wire logic              reset_n,
  input wire logic              executing,
  input wire dfr_wr_s           rf_wr,
  input wire dfr_stat_s         status_upd,
  input wire dfr_phase_e        phase
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire logic [DATA_W-1:0]      res    = rf_wr.en ? rf_wr.data : accum;
  wire logic [OPC_HI-OPC_LO:0] opc    = instr_word[OPC_HI:OPC_LO];
  wire logic                   dbit   = instr_word[DEST_BIT];
  wire logic [ADDR_W-1:0]      afield = instr_word[ADDR_HI:ADDR_LO];
  phase_order_a: assert property (phase == PH_Q4 |=> phase == PH_Q1)
    else $error("phase order");
  opcode_match_a: assert property (phase == PH_Q1 |=>
    executing == ($past(opc) == OPC_DECR)) else $error("decode");
  dest_select_a: assert property (phase == PH_Q1 && opc == OPC_DECR |->
    ##4 status_upd.we && rf_wr.en == $past(dbit, 4)) else $error("destination");
  write_addr_a: assert property (phase == PH_Q1 && opc == OPC_DECR |->
    ##4 rf_wr.addr == $past(afield, 4)) else $error("write address");
  decr_value_a: assert property (executing && phase == PH_Q2 |->
    ##3 status_upd.we && res == DATA_W'($past(rf_rd_data, 3) - ONE)) else $error("value");
  zero_flag_a: assert property (status_upd.we |-> status_upd.zero == (res == ZERO))
    else $error("zero flag");
  refuse_op_a: assert property (!executing && phase == PH_Q2 |->
    ##3 !status_upd.we && !rf_wr.en) else $error("refused op");
  accum_hold_a: assert property ($changed(accum) |-> status_upd.we && !rf_wr.en)
    else $error("accum hold");
endmodule
bind dfr_exec dfr_exec_checker u_chk (
  .instr_word (instr_word),
  .rf_rd_data (rf_rd_data),
  .accum      (accum),
  .core_clk   (core_clk),
  .reset_n    (reset_n),
  .executing  (executing),
  .rf_wr      (rf_wr),
  .status_upd (status_upd),
  .phase      (phase)
);
`default_nettype wire

// file: decrement_register_instruction_test.sv
`timescale 1ns/1ps
`default_nettype none
module decrement_register_instruction_test;
  import dfr_pkg::*;
  logic core_clk, reset_n, executing;
  logic [WORD_W-1:0] instr_word;
  logic [ADDR_W-1:0] rf_rd_addr;
  logic [DATA_W-1:0] rf_rd_data, accum;
  dfr_wr_s rf_wr;
  dfr_stat_s status_upd;
  dfr_phase_e phase;
  int mismatches = 0, comparisons = 0, cycles = 0;
  wire logic [7:0] flags = {4'h0, executing, status_upd.we, rf_wr.en, status_upd.zero};
  dfr_exec u_dut (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .instr_word (instr_word),
    .rf_rd_addr (rf_rd_addr),
    .rf_rd_data (rf_rd_data),
    .rf_wr      (rf_wr),
    .accum      (accum),
    .status_upd (status_upd),
    .phase      (phase),
    .executing  (executing)
  );
  dfr_rf_model u_rf (
    .rf_rd_addr (rf_rd_addr),
    .rf_rd_data (rf_rd_data),
    .core_clk   (core_clk),
    .rf_wr      (rf_wr)
  );
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (++cycles == 2000) begin
    mismatches++;
    results();
  end
  task automatic chk(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Word present for one Q1 only, then checked in the next Q1
  task automatic run(input logic [5:0] op, input logic d, input logic [6:0] a);
    do @(negedge core_clk); while (phase !== PH_Q4);
    @(posedge core_clk) instr_word <= {op, d, a};
    @(posedge core_clk) instr_word <= 14'h0000;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic t_to_acc;
    run(OPC_DECR, 1'b0, 7'h05);
    chk(accum, 8'h04);
    chk(flags, 8'h0C);
    chk({4'h0, phase}, 8'h01);
    chk(u_rf.mem[5], 8'h05);
    $display("to_acc done");
  endtask
  task automatic t_back;
    run(OPC_DECR, 1'b1, 7'h01);
    chk(rf_wr.data, 8'h00);
    chk({1'b0, rf_wr.addr}, 8'h01);
    chk({1'b0, rf_rd_addr}, 8'h01);
    chk(flags, 8'h0F);
    chk(accum, 8'h04);
    $display("back done");
  endtask
  task automatic t_wrap;
    run(OPC_DECR, 1'b0, 7'h00);
    chk(accum, 8'hFF);
    chk(flags, 8'h0C);
    chk(u_rf.mem[1], 8'h00);
    $display("wrap done");
  endtask
  task automatic t_refuse;
    run(6'h0A, 1'b1, 7'h05);
    chk(flags, 8'h00);
    chk(accum, 8'hFF);
    chk(u_rf.mem[5], 8'h05);
    $display("refuse done");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    instr_word = 14'h0000;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    t_to_acc();
    t_back();
    t_wrap();
    t_refuse();
    results();
  end
endmodule
`default_nettype wire
